/* bit_flag_transfer_ops.v */
// Execution unit for shift, bit, flag, transfer and control operations
//
// Behaviour
// RL1: Rotate right via carry, updates ZCNV, one clock
// RL2: Copy selected source bit into bit-copy flag
// RL3: Write bit-copy flag into destination bit
// RL4: Set or clear signed-test flag only
// RL5: Set or clear overflow flag only
// RL6: Set or clear half-carry flag only
// RL7: Post-increment load reads then bumps pointer
// RL8: Pre-decrement load drops pointer then reads
// RL9: Displaced load at pointer plus displacement
// RL10: Direct load from encoded address, two clocks
// RL11: Post-increment store writes then bumps pointer
// RL12: Pre-decrement store drops pointer then writes
// RL13: Displaced store, pointer kept, two clocks
// RL14: Direct store to encoded address, two clocks
// RL15: Program memory read via third pointer, three clocks
// RL16: Push and pop take two clocks each
// RL17: Sleep issues in one clock, no flags
// RL18: Watchdog restart pulse in one clock
// RL19: Break for debug only; no-op one clock
// RL20: Signed shift keeps bit 7, updates ZCNV
// RL21: Nibble swap in one clock, no flags
// RL22: Moves, pair copy, immediate, ports: one clock
// RL23: Set or clear global interrupt enable only
`timescale 1ns/1ps
`include "bit_flag_transfer_ops_regs.vh"

module bit_flag_transfer_ops #(
   parameter [15:0] SP_INIT = `SP_RESET     // Stack pointer after reset
) (
   input  wire        core_clk_i,           // System clock, 250 MHz
   input  wire        reset_i,              // Synchronous reset, active high
   input  wire        op_valid_i,           // Operation offered this cycle
   input  wire [4:0]  op_code_i,            // Operation code
   input  wire [4:0]  op_dst_i,             // Destination register index
   input  wire [4:0]  op_src_i,             // Source register index
   input  wire [2:0]  op_bit_i,             // Bit or flag selector
   input  wire [1:0]  op_ptr_i,             // Pointer pair selector
   input  wire [1:0]  op_mode_i,            // Pointer addressing mode
   input  wire [5:0]  op_disp_i,            // Displacement
   input  wire [7:0]  op_imm_i,             // Immediate byte
   input  wire [15:0] op_addr_i,            // Direct data address
   input  wire [5:0]  op_port_i,            // I/O port number
   input  wire [7:0]  io_rdata_i,           // Value of the addressed input port
   input  wire [7:0]  dmem_rdata_i,         // Data memory read byte
   input  wire [7:0]  pmem_rdata_i,         // Program memory read byte
   input  wire [4:0]  view_sel_i,           // Register to show on view_data_o
   output reg         busy_o,               // Multi-cycle operation in progress
   output reg  [7:0]  flags_o,              // Flags register
   output reg  [15:0] sp_o,                 // Stack pointer
   output reg  [7:0]  view_data_o,          // Selected register contents
   output reg  [15:0] dmem_addr_o,          // Data memory address
   output reg  [7:0]  dmem_wdata_o,         // Data memory write byte
   output reg         dmem_we_o,            // Data memory write strobe
   output reg         dmem_re_o,            // Data memory read strobe
   output reg  [15:0] pmem_addr_o,          // Program memory byte address
   output reg         pmem_re_o,            // Program memory read strobe
   output reg  [5:0]  io_addr_o,            // Output port number
   output reg  [7:0]  io_wdata_o,           // Output port byte
   output reg         io_we_o,              // Output port write strobe
   output reg         sleep_o,              // Sleep request pulse
   output reg         wdt_restart_o,        // Watchdog restart pulse
   output reg         break_o               // Debug break pulse
);

   // ==========================================================
   // State
   // ==========================================================
   reg  [7:0]  rf_reg [0:31];               // General register file
   reg  [1:0]  state_reg;                   // Execution state
   reg  [4:0]  pend_dst_reg;                // Destination of pending read
   reg         pend_load_reg;               // Pending data cycle is a load
   integer     i;                           // Reset loop index

   // ==========================================================
   // Operand decode
   // ==========================================================
   wire        take       = op_valid_i && (state_reg == `S_IDLE);
   wire [4:0]  ptr_lo     = `PTR_BASE + {2'b00, op_ptr_i, 1'b0};
   wire [4:0]  ptr_hi     = ptr_lo + 5'h01;
   wire [15:0] ptr_val    = {rf_reg[ptr_hi], rf_reg[ptr_lo]};
   wire [15:0] ptr_inc    = ptr_val + 16'h0001;
   wire [15:0] ptr_dec    = ptr_val - 16'h0001;
   wire [15:0] z_val      = {rf_reg[5'h1f], rf_reg[5'h1e]};
   wire [15:0] z_inc      = z_val + 16'h0001;
   wire [7:0]  dst_val    = rf_reg[op_dst_i];
   wire [7:0]  src_val    = rf_reg[op_src_i];
   wire        carry_in   = flags_o[`FLAG_C];

   // Shift result and flags for rotate and signed shift
   reg  [7:0]  sh_res;                      // Shifted value
   reg  [7:0]  sh_flags;                    // Flags after shift
   reg  [15:0] eff_addr;                    // Data memory address for the op
   reg  [15:0] ptr_next;                    // Pointer after the op

   // ==========================================================
   // Shift unit
   // ==========================================================
   always @* begin
      sh_flags = flags_o;
      if (op_code_i == `OP_ROTATE_RIGHT_VIA_CARRY) begin
         sh_res = {carry_in, dst_val[7:1]};                  // see RL1
      end else begin
         sh_res = {dst_val[7], dst_val[7:1]};                // see RL20
      end
      sh_flags[`FLAG_C] = dst_val[0];
      sh_flags[`FLAG_Z] = (sh_res == 8'h00);
      sh_flags[`FLAG_N] = sh_res[7];
      sh_flags[`FLAG_V] = sh_res[7] ^ dst_val[0];
   end

   // ==========================================================
   // Address generation
   // ==========================================================
   always @* begin
      eff_addr = ptr_val;
      ptr_next = ptr_val;
      case (op_code_i)
         `OP_INDIRECT_LOAD, `OP_INDIRECT_WRITE: begin
            if (op_mode_i == `MODE_PREDEC) begin
               eff_addr = ptr_dec;                           // see RL8
               ptr_next = ptr_dec;                           // see RL12
            end else if (op_mode_i == `MODE_POSTINC) begin
               ptr_next = ptr_inc;                           // see RL7
            end
         end
         `OP_DISPLACED_LOAD, `OP_DISPLACED_WRITE: begin
            eff_addr = ptr_val + {10'h000, op_disp_i};       // see RL9
         end
         `OP_DIRECT_DATA_LOAD, `OP_DIRECT_DATA_WRITE: begin
            eff_addr = op_addr_i;                            // see RL10
         end
         `OP_PUSH: begin
            eff_addr = sp_o;
         end
         `OP_POP: begin
            eff_addr = sp_o + 16'h0001;
         end
         default: begin
            eff_addr = ptr_val;
         end
      endcase
   end

   // ==========================================================
   // Execution
   // ==========================================================
   always @(posedge core_clk_i) begin
      if (reset_i) begin
         for (i = 0; i < 32; i = i + 1) begin
            rf_reg[i] <= 8'h00;
         end
         state_reg     <= `S_IDLE;
         pend_dst_reg  <= 5'h00;
         pend_load_reg <= 1'b0;
         busy_o        <= 1'b0;
         flags_o       <= `FLAGS_RESET;
         sp_o          <= SP_INIT;
         view_data_o   <= 8'h00;
         dmem_addr_o   <= 16'h0000;
         dmem_wdata_o  <= 8'h00;
         dmem_we_o     <= 1'b0;
         dmem_re_o     <= 1'b0;
         pmem_addr_o   <= 16'h0000;
         pmem_re_o     <= 1'b0;
         io_addr_o     <= 6'h00;
         io_wdata_o    <= 8'h00;
         io_we_o       <= 1'b0;
         sleep_o       <= 1'b0;
         wdt_restart_o <= 1'b0;
         break_o       <= 1'b0;
      end else begin
         // Strobes last one cycle unless re-armed below
         dmem_we_o     <= 1'b0;
         dmem_re_o     <= 1'b0;
         pmem_re_o     <= 1'b0;
         io_we_o       <= 1'b0;
         sleep_o       <= 1'b0;
         wdt_restart_o <= 1'b0;
         break_o       <= 1'b0;
         view_data_o   <= rf_reg[view_sel_i];
         case (state_reg)
            `S_IDLE: begin
               if (take) begin
                  case (op_code_i)
                     // Single-cycle register and flag work
                     `OP_ROTATE_RIGHT_VIA_CARRY, `OP_SIGNED_RIGHT_SHIFT: begin
                        rf_reg[op_dst_i] <= sh_res;          // see RL1
                        flags_o          <= sh_flags;        // see RL20
                     end
                     `OP_SWAP: begin
                        rf_reg[op_dst_i] <= {dst_val[3:0], dst_val[7:4]}; // see RL21
                     end
                     `OP_BSET: begin
                        flags_o[op_bit_i] <= 1'b1;           // see RL4, RL5, RL6, RL23
                     end
                     `OP_BCLR: begin
                        flags_o[op_bit_i] <= 1'b0;           // see RL4, RL5, RL6, RL23
                     end
                     `OP_BIT_TO_FLAG_STORE: begin
                        flags_o[`FLAG_T] <= src_val[op_bit_i]; // see RL2
                     end
                     `OP_FLAG_TO_BIT_LOAD: begin
                        rf_reg[op_dst_i][op_bit_i] <= flags_o[`FLAG_T]; // see RL3
                     end
                     `OP_MOV: begin
                        rf_reg[op_dst_i] <= src_val;         // see RL22
                     end
                     `OP_REGISTER_PAIR_COPY: begin
                        // Pair copy uses even indices only
                        rf_reg[{op_dst_i[4:1], 1'b0}] <= rf_reg[{op_src_i[4:1], 1'b0}];
                        rf_reg[{op_dst_i[4:1], 1'b1}] <= rf_reg[{op_src_i[4:1], 1'b1}]; // see RL22
                     end
                     `OP_IMMEDIATE_LOAD: begin
                        rf_reg[op_dst_i] <= op_imm_i;        // see RL22
                     end
                     `OP_IN: begin
                        rf_reg[op_dst_i] <= io_rdata_i;      // see RL22
                     end
                     `OP_OUT: begin
                        io_addr_o  <= op_port_i;
                        io_wdata_o <= src_val;
                        io_we_o    <= 1'b1;                  // see RL22
                     end
                     // Data memory reads: address now, capture next edge
                     `OP_INDIRECT_LOAD, `OP_DISPLACED_LOAD, `OP_DIRECT_DATA_LOAD, `OP_POP: begin
                        dmem_addr_o   <= eff_addr;
                        dmem_re_o     <= 1'b1;
                        pend_dst_reg  <= op_dst_i;
                        pend_load_reg <= 1'b1;
                        busy_o        <= 1'b1;
                        state_reg     <= `S_DATA;            // see RL7, RL8, RL9, RL10
                        if (op_code_i == `OP_INDIRECT_LOAD) begin
                           rf_reg[ptr_lo] <= ptr_next[7:0];
                           rf_reg[ptr_hi] <= ptr_next[15:8]; // see RL7, RL8
                        end
                        if (op_code_i == `OP_POP) begin
                           sp_o <= eff_addr;                 // see RL16
                        end
                     end
                     // Data memory writes: strobe now, finish next edge
                     `OP_INDIRECT_WRITE, `OP_DISPLACED_WRITE,
                     `OP_DIRECT_DATA_WRITE, `OP_PUSH: begin
                        dmem_addr_o   <= eff_addr;
                        dmem_wdata_o  <= src_val;
                        dmem_we_o     <= 1'b1;
                        pend_load_reg <= 1'b0;
                        busy_o        <= 1'b1;
                        state_reg     <= `S_DATA;            // see RL11, RL12, RL13, RL14
                        if (op_code_i == `OP_INDIRECT_WRITE) begin
                           rf_reg[ptr_lo] <= ptr_next[7:0];
                           rf_reg[ptr_hi] <= ptr_next[15:8]; // see RL11, RL12
                        end
                        if (op_code_i == `OP_PUSH) begin
                           sp_o <= sp_o - 16'h0001;          // see RL16
                        end
                     end
                     // Program memory read through the third pointer
                     `OP_PROGRAM_MEMORY_READ, `OP_PROGRAM_MEMORY_READ_R0: begin
                        pmem_addr_o  <= z_val;
                        pmem_re_o    <= 1'b1;
                        busy_o       <= 1'b1;
                        state_reg    <= `S_PROG1;            // see RL15
                        if (op_code_i == `OP_PROGRAM_MEMORY_READ_R0) begin
                           pend_dst_reg <= 5'h00;
                        end else begin
                           pend_dst_reg <= op_dst_i;
                        end
                        if (op_code_i == `OP_PROGRAM_MEMORY_READ &&
                            op_mode_i == `MODE_POSTINC) begin
                           rf_reg[5'h1e] <= z_inc[7:0];
                           rf_reg[5'h1f] <= z_inc[15:8];     // see RL15
                        end
                     end
                     // Control operations
                     `OP_SLEEP: begin
                        sleep_o <= 1'b1;                     // see RL17
                     end
                     `OP_WATCHDOG_RESTART: begin
                        wdt_restart_o <= 1'b1;               // see RL18
                     end
                     `OP_BREAK: begin
                        break_o <= 1'b1;                     // see RL19
                     end
                     default: begin
                        // No operation: one idle clock
                        busy_o <= 1'b0;                      // see RL19
                     end
                  endcase
               end
            end
            `S_DATA: begin
               // Second clock of a data transfer
               if (pend_load_reg) begin
                  rf_reg[pend_dst_reg] <= dmem_rdata_i;      // see RL7, RL16
               end
               busy_o    <= 1'b0;
               state_reg <= `S_IDLE;
            end
            `S_PROG1: begin
               // Program memory access time
               state_reg <= `S_PROG2;
            end
            `S_PROG2: begin
               rf_reg[pend_dst_reg] <= pmem_rdata_i;         // see RL15
               busy_o    <= 1'b0;
               state_reg <= `S_IDLE;
            end
            default: begin
               busy_o    <= 1'b0;
               state_reg <= `S_IDLE;
            end
         endcase
      end
   end

endmodule // bit_flag_transfer_ops

/* bit_flag_transfer_ops_chk.sv */
// Concurrent checks on the ports of the bit, flag and transfer unit
`timescale 1ns/1ps
`include "bit_flag_transfer_ops_regs.vh"
module bit_flag_transfer_ops_chk (
   input wire        core_clk_i,     // System clock
   input wire        reset_i,        // Synchronous reset
   input wire        op_valid_i,     // Operation offered
   input wire [4:0]  op_code_i,      // Operation code
   input wire [2:0]  op_bit_i,       // Flag index
   input wire        busy_o,         // Extra cycles running
   input wire [7:0]  flags_o,        // Flags register
   input wire [15:0] sp_o,           // Stack pointer
   input wire [15:0] dmem_addr_o,    // Data address
   input wire        dmem_we_o,      // Data write strobe
   input wire        sleep_o,        // Sleep pulse
   input wire        wdt_restart_o   // Watchdog pulse
);
   // ==========================================
   // Decode of the offered operation
   wire take_w = op_valid_i & ~busy_o;                    // Accepted at this edge
   wire data_w = (op_code_i >= `OP_INDIRECT_LOAD && op_code_i <= `OP_DIRECT_DATA_WRITE)
                 || op_code_i == `OP_PUSH || op_code_i == `OP_POP; // Two-clock data ops
   wire prog_w = op_code_i == `OP_PROGRAM_MEMORY_READ      // Three-clock reads
                 || op_code_i == `OP_PROGRAM_MEMORY_READ_R0;
   wire keep_w = op_code_i inside {`OP_SWAP, `OP_FLAG_TO_BIT_LOAD, `OP_MOV,
                 `OP_REGISTER_PAIR_COPY, `OP_IMMEDIATE_LOAD, `OP_IN, `OP_OUT,
                 `OP_NOP, `OP_SLEEP, `OP_WATCHDOG_RESTART};   // Flag-neutral ops

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   // ==========================================
   // Busy profiles of multi-cycle operations
   sequence two_clk_s; busy_o ##1 !busy_o; endsequence
   sequence three_clk_s; busy_o ##1 busy_o ##1 !busy_o; endsequence

   a_data_two_clk:
      assert property (take_w && data_w |=> two_clk_s) else $error("Data op length wrong");
   a_prog_three_clk:
      assert property (take_w && prog_w |=> three_clk_s) else $error("Program read length wrong");
   a_single_no_busy:
      assert property (take_w && !data_w && !prog_w |=> !busy_o) else $error("Single op stalled");
   a_set_one_flag:
      assert property (take_w && op_code_i == `OP_BSET |=>
         flags_o == ($past(flags_o) | (8'h01 << $past(op_bit_i)))) else $error("Flag set wrong");
   a_clear_one_flag:
      assert property (take_w && op_code_i == `OP_BCLR |=>
         flags_o == ($past(flags_o) & ~(8'h01 << $past(op_bit_i)))) else $error("Flag clear wrong");
   a_flags_kept:
      assert property (take_w && keep_w |=> $stable(flags_o)) else $error("Flags disturbed");
   a_push_stack:
      assert property (take_w && op_code_i == `OP_PUSH |=> dmem_we_o
         && dmem_addr_o == $past(sp_o) && sp_o == $past(sp_o) - 16'h0001) else $error("Push wrong");
   a_pop_stack:
      assert property (take_w && op_code_i == `OP_POP |=> dmem_addr_o == $past(sp_o) + 16'h0001
         && sp_o == $past(sp_o) + 16'h0001) else $error("Pop wrong");
   a_sleep_cause:
      assert property (sleep_o |-> $past(take_w && op_code_i == `OP_SLEEP))
         else $error("Sleep pulse without cause");
   a_wdt_pulse:
      assert property (take_w && op_code_i == `OP_WATCHDOG_RESTART |=> wdt_restart_o)
         else $error("No restart");
endmodule // bit_flag_transfer_ops_chk

bind bit_flag_transfer_ops bit_flag_transfer_ops_chk bit_flag_transfer_ops_chk_i (.core_clk_i,
   .reset_i, .op_valid_i, .op_code_i, .op_bit_i, .busy_o, .flags_o, .sp_o, .dmem_addr_o,
   .dmem_we_o, .sleep_o, .wdt_restart_o);

/* bit_flag_transfer_ops_regs.vh */
// Constants for the bit, flag and transfer execution unit
`ifndef BIT_FLAG_TRANSFER_OPS_REGS_VH
`define BIT_FLAG_TRANSFER_OPS_REGS_VH

// Operation codes presented on op_code_i
`define OP_NOP        5'h00
`define OP_ROTATE_RIGHT_VIA_CARRY  5'h01
`define OP_SIGNED_RIGHT_SHIFT      5'h02
`define OP_SWAP                    5'h03
`define OP_BSET                    5'h04
`define OP_BCLR                    5'h05
`define OP_BIT_TO_FLAG_STORE       5'h06
`define OP_FLAG_TO_BIT_LOAD        5'h07
`define OP_MOV                     5'h08
`define OP_REGISTER_PAIR_COPY      5'h09
`define OP_IMMEDIATE_LOAD          5'h0a
`define OP_INDIRECT_LOAD           5'h0b
`define OP_INDIRECT_WRITE          5'h0c
`define OP_DISPLACED_LOAD          5'h0d
`define OP_DISPLACED_WRITE         5'h0e
`define OP_DIRECT_DATA_LOAD        5'h0f
`define OP_DIRECT_DATA_WRITE       5'h10
`define OP_PROGRAM_MEMORY_READ     5'h11
`define OP_PROGRAM_MEMORY_READ_R0  5'h12
`define OP_IN                      5'h13
`define OP_OUT                     5'h14
`define OP_PUSH                    5'h15
`define OP_POP                     5'h16
`define OP_SLEEP                   5'h17
`define OP_WATCHDOG_RESTART        5'h18
`define OP_BREAK      5'h19

// Pointer pair selection and addressing modes
`define PTR_X         2'h0
`define PTR_Y         2'h1
`define PTR_Z         2'h2
`define MODE_PLAIN    2'h0
`define MODE_POSTINC  2'h1
`define MODE_PREDEC   2'h2
`define PTR_BASE      5'h1a

// Bit positions inside the flags register
`define FLAG_C        3'h0
`define FLAG_Z        3'h1
`define FLAG_N        3'h2
`define FLAG_V        3'h3
`define FLAG_S        3'h4
`define FLAG_H        3'h5
`define FLAG_T        3'h6
`define FLAG_I        3'h7

// Reset values
`define FLAGS_RESET   8'h00
`define SP_RESET      16'h00df

// Execution states
`define S_IDLE        2'h0
`define S_DATA        2'h1
`define S_PROG1       2'h2
`define S_PROG2       2'h3

`endif

/* bit_flag_transfer_ops_tb_top.sv */
// Self-checking bench for the bit, flag and transfer unit
`timescale 1ns/1ps
`include "bit_flag_transfer_ops_regs.vh"
module bit_flag_transfer_ops_tb_top;
   // ==========================================
   // Stimulus, observed outputs and model state
   logic        core_clk_i, reset_i, op_valid_i;               // Clock and control
   logic [4:0]  op_code_i, op_dst_i, op_src_i, view_sel_i;    // Op fields
   logic [2:0]  op_bit_i;                                      // Bit selector
   logic [1:0]  op_ptr_i, op_mode_i;                           // Pointer fields
   logic [5:0]  op_disp_i, op_port_i;                          // Displacement, port
   logic [7:0]  op_imm_i, io_rdata_i, dmem_rdata_i, pmem_rdata_i; // Data inputs
   logic [15:0] op_addr_i;                                     // Direct address
   wire         busy_o, dmem_we_o, dmem_re_o, pmem_re_o, io_we_o;
   wire         sleep_o, wdt_restart_o, break_o;
   wire  [7:0]  flags_o, view_data_o, dmem_wdata_o, io_wdata_o;
   wire  [15:0] sp_o, dmem_addr_o, pmem_addr_o;
   wire  [5:0]  io_addr_o;
   int          n_errors, total_checks, k, c;                  // Counters
   int          rf[32];                                        // Model register file
   int          fl, sp_m;                                      // Model flags and stack

   // Free-running 250 MHz clock
   initial begin
      core_clk_i = 0;
      forever #2 core_clk_i = ~core_clk_i;
   end

   bit_flag_transfer_ops bit_flag_transfer_ops_i (.core_clk_i, .reset_i, .op_valid_i,
      .op_code_i, .op_dst_i, .op_src_i, .op_bit_i, .op_ptr_i, .op_mode_i, .op_disp_i,
      .op_imm_i, .op_addr_i, .op_port_i, .io_rdata_i, .dmem_rdata_i, .pmem_rdata_i,
      .view_sel_i, .busy_o, .flags_o, .sp_o, .view_data_o, .dmem_addr_o, .dmem_wdata_o,
      .dmem_we_o, .dmem_re_o, .pmem_addr_o, .pmem_re_o, .io_addr_o, .io_wdata_o, .io_we_o,
      .sleep_o, .wdt_restart_o, .break_o);

   // ==========================================
   // Compare, report and finish
   task cmp(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask

   task end_of_test;
      $display("Checks %0d, mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Flags, stack and all registers read through the view port
   task chk_state;
      int i;
      cmp(flags_o, fl & 255);
      cmp(sp_o, sp_m & 65535);
      for (i = 0; i <= 32; i++) begin
         if (i > 0) cmp(view_data_o, rf[i-1]);
         if (i < 32) view_sel_i = i;
         @(negedge core_clk_i);
      end
   endtask

   // Five-cycle reset, then model cleared and state compared
   task do_reset;
      reset_i = 1;
      op_valid_i = 0;
      repeat (5) @(negedge core_clk_i);
      reset_i = 0;
      foreach (rf[i]) rf[i] = 0;
      fl = 0;
      sp_m = `SP_RESET;
      chk_state;
   endtask

   // Offer one op; check strobes, addresses, refusal while busy and length
   task go(input int cy, input logic [6:0] e, input logic [15:0] a, input logic [7:0] wd);
      int n;
      op_valid_i = 1;
      @(negedge core_clk_i);
      cmp({dmem_we_o, dmem_re_o, pmem_re_o, io_we_o, sleep_o, wdt_restart_o, break_o}, e);
      if (e[6:5] != 0) cmp(dmem_addr_o, a);
      if (e[6]) cmp(dmem_wdata_o, wd);
      if (e[4]) cmp(pmem_addr_o, a);
      if (e[3]) cmp({io_addr_o, io_wdata_o}, {a[5:0], wd});
      // A sleep offered while busy must be ignored
      op_code_i = `OP_SLEEP;
      op_valid_i = (busy_o === 1'b1);
      n = 0;
      while (busy_o !== 1'b0 && n < 4) begin
         @(negedge core_clk_i);
         op_valid_i = 0;
         n++;
         cmp(sleep_o, 0);
      end
      cmp(n, cy);
      if (n == 4) end_of_test;
   endtask

   // Random operands, reference result, then run and compare
   task do_op(input logic [4:0] op, input int fb);
      int d, s, b, p, pv, o, r, a, cy, wd;
      logic [6:0] e;
      d = $urandom % 32; s = $urandom % 26; p = $urandom % 3;
      b = (fb < 0) ? $urandom % 8 : fb;
      op_mode_i = $urandom % 3;
      if (op == `OP_DISPLACED_LOAD || op == `OP_DISPLACED_WRITE) p = 1 + $urandom % 2;
      if (op == `OP_PROGRAM_MEMORY_READ || op == `OP_PROGRAM_MEMORY_READ_R0) begin
         p = 2;
         op_mode_i = (op == `OP_PROGRAM_MEMORY_READ) ? $urandom % 2 : 0;
      end
      {op_code_i, op_dst_i, op_src_i, op_bit_i, op_ptr_i} = {op, 5'(d), 5'(s), 3'(b), 2'(p)};
      {op_disp_i, op_imm_i, op_addr_i, op_port_i} = {$urandom, $urandom};
      {io_rdata_i, dmem_rdata_i, pmem_rdata_i} = $urandom;
      if (op == `OP_PROGRAM_MEMORY_READ_R0) d = 0;
      pv = rf[26+2*p] + 256 * rf[27+2*p];
      o = rf[d]; r = -1; a = 0; cy = 0; wd = rf[s]; e = 0;
      case (op)
         `OP_ROTATE_RIGHT_VIA_CARRY, `OP_SIGNED_RIGHT_SHIFT: begin
            r = ((op == `OP_ROTATE_RIGHT_VIA_CARRY) ? (fl & 1) << 7 : o & 128) | (o >> 1);
            fl = (fl&240) | (((r>>7)^(o&1))<<3) | ((r>>7)<<2) | ((r==0)<<1) | (o&1);
         end
         `OP_SWAP: r = ((o << 4) | (o >> 4)) & 255;
         `OP_BSET: fl = fl | (1 << b);
         `OP_BCLR: fl = fl & ~(1 << b);
         `OP_BIT_TO_FLAG_STORE: fl = (fl & 191) | (((rf[s] >> b) & 1) << 6);
         `OP_FLAG_TO_BIT_LOAD: r = (o & ~(1 << b)) | (((fl >> 6) & 1) << b);
         `OP_MOV: r = rf[s];
         `OP_REGISTER_PAIR_COPY: begin
            d = d & 30;
            rf[d+1] = rf[(s&30)+1];
            r = rf[s&30];
         end
         `OP_IMMEDIATE_LOAD: r = op_imm_i;
         `OP_IN: r = io_rdata_i;
         `OP_OUT: begin e = 7'h08; a = op_port_i; end
         `OP_INDIRECT_LOAD, `OP_INDIRECT_WRITE: begin
            if (op_mode_i == 2) pv = pv - 1;
            a = pv;
            if (op_mode_i == 1) pv = pv + 1;
         end
         `OP_DISPLACED_LOAD, `OP_DISPLACED_WRITE: a = pv + op_disp_i;
         `OP_DIRECT_DATA_LOAD, `OP_DIRECT_DATA_WRITE: a = op_addr_i;
         `OP_PROGRAM_MEMORY_READ, `OP_PROGRAM_MEMORY_READ_R0: begin
            a = pv;
            pv = pv + op_mode_i;
            e = 7'h10;
            cy = 2;
            r = pmem_rdata_i;
         end
         `OP_PUSH: begin a = sp_m; sp_m = sp_m - 1; end
         `OP_POP: begin sp_m = sp_m + 1; a = sp_m; end
         `OP_SLEEP: e = 7'h04;
         `OP_WATCHDOG_RESTART: e = 7'h02;
         `OP_BREAK: e = 7'h01;
         default: ;
      endcase
      if (op inside {`OP_INDIRECT_LOAD, `OP_DISPLACED_LOAD, `OP_DIRECT_DATA_LOAD, `OP_POP}) begin
         e = 7'h20;
         cy = 1;
         r = dmem_rdata_i;
      end
      if (op inside {`OP_INDIRECT_WRITE, `OP_DISPLACED_WRITE,
                     `OP_DIRECT_DATA_WRITE, `OP_PUSH}) begin
         e = 7'h40;
         cy = 1;
      end
      if (op inside {`OP_INDIRECT_LOAD, `OP_INDIRECT_WRITE,
                     `OP_PROGRAM_MEMORY_READ, `OP_PROGRAM_MEMORY_READ_R0}) begin
         rf[26+2*p] = pv & 255;
         rf[27+2*p] = (pv >> 8) & 255;
      end
      if (r >= 0) rf[d] = r & 255;
      go(cy, e, a, wd);
      chk_state;
   endtask

   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(32'hfcf7));
      {reset_i, op_valid_i, op_code_i, op_dst_i, op_src_i, view_sel_i, op_bit_i} = '0;
      {op_ptr_i, op_mode_i, op_disp_i, op_port_i, op_imm_i, op_addr_i} = '0;
      {io_rdata_i, dmem_rdata_i, pmem_rdata_i} = '0;
      n_errors = 0;
      total_checks = 0;
      do_reset;
      $display("Test reset values done");
      for (k = 0; k < 6; k++) for (c = 0; c < 26; c++) do_op(5'(c), -1);
      $display("Test all operations done");
      for (k = 0; k < 8; k++) begin
         do_op(`OP_BSET, k);
         do_op(`OP_BCLR, k);
      end
      $display("Test flag indices done");
      do_reset;
      for (k = 0; k < 2; k++) for (c = 0; c < 26; c++) do_op(5'(c), -1);
      $display("Test second reset done");
      end_of_test;
   end
endmodule // bit_flag_transfer_ops_tb_top
